/* logic/ebra_dev.sv */
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// device end: bus cycle sequencer with ready and hold arbitration
module ebra_dev
  import ebra_pkg::*;
(
  input  wire logic              i_mclk,       // cpu clock
  input  wire logic              i_arst_n,     // async reset, active low
  ebra_link_if.dev               link,         // external bus pins
  input  wire logic              i_start,      // start a cycle, pulse
  input  wire logic              i_write,      // cycle is a write
  input  wire logic [BUS_AW-1:0] i_addr,       // cycle address
  input  wire logic [BUS_DW-1:0] i_wdata,      // write data
  input  wire logic              i_mux_mode,   // multiplexed bus mode
  input  wire logic              i_tri_ws,     // tristate wait state on
  input  wire logic              i_rw_delay,   // read/write delay on
  input  wire logic [WS_W-1:0]   i_cycle_ws,   // cycle time wait states
  input  wire logic              i_want_bus,   // ask for bus back
  output logic                   o_busy,       // request pending or sequencer not idle
  output logic                   o_done,       // cycle ended, pulse
  output logic [BUS_DW-1:0]      o_rdata,      // read data of last cycle
  output logic                   o_held        // bus handed over
);
  ////////////////////////////////////////////////////////////////////
  // state
  ebra_state_t       st_q, st_d;        // sequencer state
  logic              ph_q, ph_d;        // bus clock phase
  logic              rdy_m_q, rdy_s_q;  // ready synchroniser
  logic              hld_m_q, hld_s_q;  // hold synchroniser
  logic              pend_q, pend_d;    // accepted request waiting
  logic              wr_q, wr_d;        // latched direction
  logic [BUS_AW-1:0] adr_q, adr_d;      // latched address
  logic [BUS_DW-1:0] wdt_q, wdt_d;      // latched write data
  logic              mux_q, mux_d;      // latched mux mode
  logic              tri_q, tri_d;      // latched tristate option
  logic              dly_q, dly_d;      // latched delay option
  logic [WS_W-1:0]   cws_q, cws_d;      // latched wait states
  logic [WS_W-1:0]   wcnt_q, wcnt_d;    // wait state counter
  logic [BUS_DW-1:0] rdat_q, rdat_d;    // captured read data
  logic              done_q, done_d;    // cycle end pulse
  logic              busy_q, busy_d;    // busy flag
  logic              held_q, held_d;    // bus handed over, user copy
  // pin registers
  logic              ale_q, ale_d;      // latch enable
  logic              rd_n_q, rd_n_d;    // read strobe
  logic              wr_n_q, wr_n_d;    // write strobe
  logic              cs_q, cs_d;        // chip select level
  logic              csoe_q, csoe_d;    // chip select enable, low drives
  logic              ctoe_q, ctoe_d;    // control enable, low drives
  logic              doe_q, doe_d;      // data enable, low drives
  logic              gnt_q, gnt_d;      // hold grant, active low
  logic              brq_q, brq_d;      // bus request, active low

  // strobe is low in command and ready phases
  function automatic logic cmd_phase(input ebra_state_t s);
    return (s == ST_CMD) || (s == ST_RDY);
  endfunction

  // outputs are released while the bus is handed over
  function automatic logic released(input ebra_state_t s);
    return (s == ST_HOLD) || (s == ST_REGN);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb
  begin
    st_d   = st_q;
    ph_d   = !ph_q;                            // bus clock = 2 cpu clocks
    pend_d = pend_q;
    wr_d   = wr_q;
    adr_d  = adr_q;
    wdt_d  = wdt_q;
    mux_d  = mux_q;
    tri_d  = tri_q;
    dly_d  = dly_q;
    cws_d  = cws_q;
    wcnt_d = wcnt_q;
    rdat_d = rdat_q;
    done_d = 1'h0;
    if (i_start && !busy_q)
    begin
      pend_d = 1'h1;
      wr_d   = i_write;
      adr_d  = i_addr;
      wdt_d  = i_wdata;
      mux_d  = i_mux_mode;
      tri_d  = i_tri_ws;
      dly_d  = i_rw_delay;
      cws_d  = i_cycle_ws;
    end
    if (ph_q)                                  // last cpu clock of a bus period
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (!hld_s_q)
            st_d = ST_HOLD;                    // only between cycles
          else if (pend_q && rdy_s_q)
          begin
            pend_d = 1'h0;
            st_d   = ST_ADDR;
          end
        end
        ST_ADDR:
        begin
          wcnt_d = cws_q;
          st_d   = dly_q ? ST_DLY : ST_CMD;    // delayed leading edge
        end
        ST_DLY:
          st_d = ST_CMD;
        ST_CMD:
        begin
          if (wcnt_q == '0)
            st_d = ST_RDY;
          else
            wcnt_d = wcnt_q - 1'h1;            // programmed waits first
        end
        ST_RDY:
        begin
          if (!rdy_s_q)                        // low ends, high waits
          begin
            rdat_d = link.data_bus;
            done_d = 1'h1;
            if (mux_q)
              st_d = ST_MUXW;
            else if (tri_q)
              st_d = ST_TRIW;
            else
              st_d = ST_IDLE;                  // zero gap demux
          end
        end
        ST_MUXW:
          st_d = tri_q ? ST_TRIW : ST_IDLE;    // two with tristate
        ST_TRIW:
          st_d = ST_IDLE;
        ST_HOLD:
        begin
          if (hld_s_q)
            st_d = ST_REGN;                    // hold withdrawn only
        end
        ST_REGN:
          st_d = ST_IDLE;                      // drive again after grant off
        default:
          st_d = ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin levels from the next state
  always_comb
  begin
    ale_d  = (st_d == ST_ADDR);
    cs_d   = !((st_d == ST_ADDR) || (st_d == ST_DLY) || cmd_phase(st_d));
    rd_n_d = !(cmd_phase(st_d) && !wr_d);
    wr_n_d = !(cmd_phase(st_d) && wr_d);
    csoe_d = released(st_d);                   // pulled high when released
    ctoe_d = released(st_d);
    doe_d  = !(wr_d && !released(st_d) && (st_d != ST_IDLE)
               && (st_d != ST_MUXW) && (st_d != ST_TRIW));
    gnt_d  = (st_d != ST_HOLD);
    held_d = (st_d == ST_HOLD);
    brq_d  = !((st_d == ST_HOLD) && i_want_bus);
    busy_d = pend_d || (st_d != ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_q    <= ST_IDLE;
      ph_q    <= 1'h0;
      rdy_m_q <= LINE_IDLE;
      rdy_s_q <= LINE_IDLE;
      hld_m_q <= LINE_IDLE;
      hld_s_q <= LINE_IDLE;
      pend_q  <= 1'h0;
      wr_q    <= 1'h0;
      adr_q   <= '0;
      wdt_q   <= '0;
      mux_q   <= 1'h0;
      tri_q   <= 1'h0;
      dly_q   <= 1'h0;
      cws_q   <= '0;
      wcnt_q  <= '0;
      rdat_q  <= '0;
      done_q  <= 1'h0;
      busy_q  <= 1'h0;
      ale_q   <= 1'h0;
      rd_n_q  <= LINE_IDLE;
      wr_n_q  <= LINE_IDLE;
      cs_q    <= LINE_IDLE;
      csoe_q  <= 1'h0;
      ctoe_q  <= 1'h0;
      doe_q   <= OE_OFF;
      gnt_q   <= LINE_IDLE;
      held_q  <= 1'h0;
      brq_q   <= LINE_IDLE;
    end
    else
    begin
      st_q    <= st_d;
      ph_q    <= ph_d;
      rdy_m_q <= link.ready_n;                 // two stages
      rdy_s_q <= rdy_m_q;
      hld_m_q <= link.hold_n;
      hld_s_q <= hld_m_q;
      pend_q  <= pend_d;
      wr_q    <= wr_d;
      adr_q   <= adr_d;
      wdt_q   <= wdt_d;
      mux_q   <= mux_d;
      tri_q   <= tri_d;
      dly_q   <= dly_d;
      cws_q   <= cws_d;
      wcnt_q  <= wcnt_d;
      rdat_q  <= rdat_d;
      done_q  <= done_d;
      busy_q  <= busy_d;
      ale_q   <= ale_d;
      rd_n_q  <= rd_n_d;
      wr_n_q  <= wr_n_d;
      cs_q    <= cs_d;
      csoe_q  <= csoe_d;
      ctoe_q  <= ctoe_d;
      doe_q   <= doe_d;
      gnt_q   <= gnt_d;
      held_q  <= held_d;
      brq_q   <= brq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pins and user outputs, all from flip-flops
  assign link.bus_clk       = ph_q;
  assign link.ale           = ale_q;
  assign link.rd_n          = rd_n_q;
  assign link.wr_n          = wr_n_q;
  assign link.addr          = adr_q;
  assign link.cs_o          = cs_q;
  assign link.cs_oe_n       = csoe_q;
  assign link.ctl_oe_n      = ctoe_q;
  assign link.dev_data      = wdt_q;
  assign link.dev_data_oe_n = doe_q;
  assign link.hold_grant_n  = gnt_q;
  assign link.bus_request_n = brq_q;
  assign o_busy             = busy_q;
  assign o_done             = done_q;
  assign o_rdata            = rdat_q;
  assign o_held             = held_q;
endmodule
`default_nettype wire

/* logic/ebra_far.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// far end: ready-stretching memory plus external hold master
module ebra_far
  import ebra_pkg::*;
#(
  parameter int READY_LOW_MIN = READY_LOW_CYC  // least ready low, link cycles
)(
  input  wire logic         i_mclk,         // user clock
  input  wire logic         i_arst_n,       // async reset, active low
  ebra_link_if.far          link,           // external bus pins
  input  wire logic         i_hold_req,     // ask for the bus, level
  input  wire logic [WS_W-1:0] i_wait_ws,   // ready waits, keep static
  output logic              o_granted,      // hold acknowledged
  output logic              o_bus_wanted    // device asks for bus back
);
  // ready low length counter saturates at fifteen
  if (READY_LOW_MIN < 1 || READY_LOW_MIN > 16)
  begin : g_low_min_chk
    $error("ready low minimum out of range");
  end

  ////////////////////////////////////////////////////////////////////
  // link domain state
  logic                 hreq_m_q, hreq_s_q;  // hold request synchroniser
  logic [WS_W-1:0]      ws_m_q, ws_s_q;      // wait count synchroniser
  logic                 hold_n_q, hold_n_d;  // hold pin
  logic                 rdy_n_q, rdy_n_d;    // ready pin
  logic [WS_W-1:0]      wcnt_q, wcnt_d;      // ready wait counter
  logic [3:0]           lcnt_q, lcnt_d;      // ready low length
  logic [BUS_DW-1:0]    rdat_q, rdat_d;      // read data out
  logic                 roe_n_q, roe_n_d;    // read data enable
  logic [BUS_DW-1:0]    mem [2**MEM_AW];     // storage
  logic                 strobe;              // any command low
  logic [MEM_AW-1:0]    idx;                 // word index

  assign strobe = !link.rd_line || !link.wr_line;
  assign idx    = link.addr_line[MEM_AW-1:0];

  // ready timing and read data
  always_comb
  begin
    hold_n_d = !hreq_s_q;                   // released at any time
    rdy_n_d  = rdy_n_q;
    wcnt_d   = wcnt_q;
    lcnt_d   = lcnt_q;
    rdat_d   = mem[idx];
    roe_n_d  = link.rd_line;
    if (rdy_n_q)
    begin
      lcnt_d = 4'h0;
      if (!strobe)
        wcnt_d = '0;
      else if (wcnt_q >= ws_s_q)
        rdy_n_d = 1'h0;                     // end the cycle
      else
        wcnt_d = wcnt_q + 1'h1;
    end
    else
    begin
      if (lcnt_q != 4'hf)
        lcnt_d = lcnt_q + 4'h1;
      // removed on command trailing edge, after the least low time
      if (!strobe && (32'(lcnt_q) + 1 >= READY_LOW_MIN))
      begin
        rdy_n_d = 1'h1;
        wcnt_d  = '0;
      end
    end
  end

  // link registers
  always_ff @(posedge link.bus_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      hreq_m_q <= 1'h0;
      hreq_s_q <= 1'h0;
      ws_m_q   <= '0;
      ws_s_q   <= '0;
      hold_n_q <= LINE_IDLE;
      rdy_n_q  <= LINE_IDLE;
      wcnt_q   <= '0;
      lcnt_q   <= 4'h0;
      rdat_q   <= '0;
      roe_n_q  <= OE_OFF;
    end
    else
    begin
      hreq_m_q <= i_hold_req;
      hreq_s_q <= hreq_m_q;
      ws_m_q   <= i_wait_ws;
      ws_s_q   <= ws_m_q;
      hold_n_q <= hold_n_d;
      rdy_n_q  <= rdy_n_d;
      wcnt_q   <= wcnt_d;
      lcnt_q   <= lcnt_d;
      rdat_q   <= rdat_d;
      roe_n_q  <= roe_n_d;
    end
  end

  // storage written while write strobe and chip select are both low
  always_ff @(posedge link.bus_clk)
  begin
    if (!link.wr_line && !link.chip_select_n)
      mem[idx] <= link.data_bus;
  end

  assign link.hold_n        = hold_n_q;
  assign link.ready_n       = rdy_n_q;
  assign link.mem_data      = rdat_q;
  assign link.mem_data_oe_n = roe_n_q;

  ////////////////////////////////////////////////////////////////////
  // user domain: grant and bus request back to levels
  logic gnt_m_q, gnt_s_q;  // grant synchroniser, second stage active high
  logic brq_m_q, brq_s_q;  // bus request synchroniser, second stage active high

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      gnt_m_q <= LINE_IDLE;
      gnt_s_q <= 1'h0;
      brq_m_q <= LINE_IDLE;
      brq_s_q <= 1'h0;
    end
    else
    begin
      gnt_m_q <= link.hold_grant_n;
      gnt_s_q <= !gnt_m_q;               // outputs straight from flops
      brq_m_q <= link.bus_request_n;
      brq_s_q <= !brq_m_q;
    end
  end

  assign o_granted    = gnt_s_q;
  assign o_bus_wanted = brq_s_q;
endmodule
`default_nettype wire

/* logic/ebra_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// external bus pins between the device and memory / bus master
interface ebra_link_if;
  import ebra_pkg::*;
  logic              bus_clk;        // bus clock out, made by the device
  logic              ale;            // address latch enable
  logic              rd_n;           // read strobe as driven
  logic              wr_n;           // write strobe as driven
  logic [BUS_AW-1:0] addr;           // address as driven
  logic              cs_o;           // chip select level as driven
  logic              cs_oe_n;        // chip select drive enable
  logic              ctl_oe_n;       // address/strobe drive enable
  logic [BUS_DW-1:0] dev_data;       // device write data
  logic              dev_data_oe_n;  // device data drive enable
  logic [BUS_DW-1:0] mem_data;       // far end read data
  logic              mem_data_oe_n;  // far end data drive enable
  logic              ready_n;        // ready, active low
  logic              hold_n;         // hold request, active low
  logic              hold_grant_n;   // hold acknowledge, active low
  logic              bus_request_n;  // device asks for the bus back
  // resolved wire levels, released lines pulled high
  logic              chip_select_n;  // resolved chip select
  logic              rd_line;        // resolved read strobe
  logic              wr_line;        // resolved write strobe
  logic [BUS_AW-1:0] addr_line;      // resolved address
  logic [BUS_DW-1:0] data_bus;       // resolved data

  assign chip_select_n = cs_oe_n ? 1'h1 : cs_o;
  assign rd_line       = ctl_oe_n ? 1'h1 : rd_n;
  assign wr_line       = ctl_oe_n ? 1'h1 : wr_n;
  assign addr_line     = ctl_oe_n ? '1 : addr;
  assign data_bus      = !dev_data_oe_n ? dev_data : (!mem_data_oe_n ? mem_data : '1);

  modport dev (
    output bus_clk, ale, rd_n, wr_n, addr, cs_o, cs_oe_n, ctl_oe_n,
    output dev_data, dev_data_oe_n, hold_grant_n, bus_request_n,
    input  ready_n, hold_n, data_bus
  );
  modport far (
    input  bus_clk, ale, rd_line, wr_line, addr_line, chip_select_n, data_bus,
    input  hold_grant_n, bus_request_n,
    output mem_data, mem_data_oe_n, ready_n, hold_n
  );
endinterface
`default_nettype wire

/* logic/ebra_pkg.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////
// shared constants and types of the bus cycle / hold arbiter
package ebra_pkg;
  localparam int BUS_AW        = 16;  // address width
  localparam int BUS_DW        = 16;  // data width
  localparam int WS_W          = 4;   // wait state counter width
  localparam int MEM_AW        = 4;   // far end memory index width
  localparam int MCLK_NS       = 4;   // cpu clock period
  localparam int BUS_CLK_NS    = 2 * MCLK_NS; // bus clock out period
  localparam int READY_LOW_NS  = 35;  // least async ready low time
  localparam int READY_LOW_CYC = (READY_LOW_NS + BUS_CLK_NS - 1) / BUS_CLK_NS;
  localparam logic LINE_IDLE   = 1'h1; // reset level of active-low lines
  localparam logic OE_OFF      = 1'h1; // reset level of data output enables

  // bus cycle states, one step per bus clock period
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,   // bus owned, no cycle
    ST_ADDR = 4'h1,   // address phase, latch enable high
    ST_DLY  = 4'h2,   // read/write delay, strobe still high
    ST_CMD  = 4'h3,   // strobe low, cycle time wait states
    ST_RDY  = 4'h4,   // strobe low, ready sampled
    ST_MUXW = 4'h5,   // multiplex wait after a cycle
    ST_TRIW = 4'h6,   // tristate wait after a cycle
    ST_HOLD = 4'h7,   // bus handed to external master
    ST_REGN = 4'h8    // grant removed, outputs still released
  } ebra_state_t;
endpackage
`default_nettype wire

/* tb/ebra_link_sva.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// link checker: sees only the interface signals, cpu clock domain
module ebra_link_sva (
  input wire logic i_mclk,         // cpu clock
  input wire logic i_arst_n,       // async reset, active low
  input wire logic bus_clk,        // bus clock out
  input wire logic rd_n,           // read strobe as driven
  input wire logic wr_n,           // write strobe as driven
  input wire logic cs_oe_n,        // chip select drive enable
  input wire logic ctl_oe_n,       // address/strobe drive enable
  input wire logic dev_data_oe_n,  // device data drive enable
  input wire logic chip_select_n,  // resolved chip select
  input wire logic ready_n,        // ready, active low
  input wire logic hold_n,         // hold request, active low
  input wire logic hold_grant_n,   // hold grant, active low
  input wire logic bus_request_n   // bus request, active low
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////////////////////////////////////
  // bus clock: high one cpu clock, low one cpu clock
  property p_bus_clk_period;
    $rose(bus_clk) |=> !bus_clk ##1 bus_clk ##1 !bus_clk;
  endproperty
  a_bus_clk_period: assert property (p_bus_clk_period)
    else $error("bus clock period wrong");
  // while granted chip select, address/strobe and data are released, chip select pulled high
  property p_grant_released;
    !hold_grant_n |-> cs_oe_n && ctl_oe_n && dev_data_oe_n && chip_select_n;
  endproperty
  a_grant_released: assert property (p_grant_released)
    else $error("outputs driven while granted");
  // grant only from idle, after a synced request
  property p_grant_after_cycle;
    $fell(hold_grant_n) |-> $past(rd_n && wr_n) && !$past(hold_n, 2);
  endproperty
  a_grant_after_cycle: assert property (p_grant_after_cycle)
    else $error("grant without request or inside a cycle");
  // grant stays while hold still asked
  property p_grant_stays;
    !hold_grant_n && !hold_n |=> !hold_grant_n;
  endproperty
  a_grant_stays: assert property (p_grant_stays)
    else $error("grant dropped while hold asked");
  // regain only after the hold request was withdrawn
  property p_regain_on_hold;
    $rose(hold_grant_n) |-> $past(hold_n, 2);
  endproperty
  a_regain_on_hold: assert property (p_regain_on_hold)
    else $error("regain without hold withdrawn");
  // outputs stay released one bus period after grant removed
  property p_regain_gap;
    $rose(hold_grant_n) |-> ctl_oe_n [*2] ##[1:2] !ctl_oe_n;
  endproperty
  a_regain_gap: assert property (p_regain_gap)
    else $error("outputs driven too early or never after grant");
  // bus request only while granted
  property p_bus_request_n_held;
    $fell(bus_request_n) |-> !hold_grant_n;
  endproperty
  a_bus_request_n_held: assert property (p_bus_request_n_held)
    else $error("bus request while not granted");
  // strobe ends only after ready was low two cpu clocks
  property p_end_needs_ready;
    $rose(rd_n && wr_n) |-> !$past(ready_n, 2);
  endproperty
  a_end_needs_ready: assert property (p_end_needs_ready)
    else $error("cycle ended without synced ready");
  // ready high keeps the strobe low
  property p_ready_waits;
    !(rd_n && wr_n) && ready_n |=> !(rd_n && wr_n);
  endproperty
  a_ready_waits: assert property (p_ready_waits)
    else $error("cycle ended while ready high");
endmodule
`default_nettype wire

/* tb/ext_bus_ready_hold_arbiter_bench.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// bench: device end and far end joined by the link interface
module ext_bus_ready_hold_arbiter_bench;
  import ebra_pkg::*;
  logic              i_mclk, i_arst_n;        // clock, reset
  logic              i_start, i_write;        // cycle request
  logic [BUS_AW-1:0] i_addr;                  // cycle address
  logic [BUS_DW-1:0] i_wdata, o_rdata;        // data
  logic              i_mux_mode, i_tri_ws;    // trailing wait modes
  logic              i_rw_delay, i_want_bus;  // delay, bus back
  logic [WS_W-1:0]   i_cycle_ws, i_wait_ws;   // wait states
  logic              i_hold_req;              // far master wants bus
  logic              o_busy, o_done, o_held;  // device status
  logic              o_granted, o_bus_wanted; // far status
  int                n_mismatch, total_checks; // counters
  int                base, g0, lat, gap;      // measured clocks

  ebra_link_if link ();
  ebra_dev ebra_dev_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .link(link),
    .i_start(i_start), .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_mux_mode(i_mux_mode), .i_tri_ws(i_tri_ws), .i_rw_delay(i_rw_delay),
    .i_cycle_ws(i_cycle_ws), .i_want_bus(i_want_bus), .o_busy(o_busy),
    .o_done(o_done), .o_rdata(o_rdata), .o_held(o_held));
  // far end keeps the slave side: ready low long enough, dropped after strobe
  ebra_far #(.READY_LOW_MIN(READY_LOW_CYC)) ebra_far_i (.i_mclk(i_mclk),
    .i_arst_n(i_arst_n), .link(link), .i_hold_req(i_hold_req),
    .i_wait_ws(i_wait_ws), .o_granted(o_granted), .o_bus_wanted(o_bus_wanted));
  ebra_link_sva ebra_link_sva_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .bus_clk(link.bus_clk), .rd_n(link.rd_n), .wr_n(link.wr_n),
    .cs_oe_n(link.cs_oe_n), .ctl_oe_n(link.ctl_oe_n),
    .dev_data_oe_n(link.dev_data_oe_n), .chip_select_n(link.chip_select_n),
    .ready_n(link.ready_n), .hold_n(link.hold_n), .hold_grant_n(link.hold_grant_n),
    .bus_request_n(link.bus_request_n));
  ////////////////////////////////////////////////////////////////////////
  // cpu clock
  initial
  begin
    i_mclk = 1'h0;
    forever #(MCLK_NS / 2) i_mclk = ~i_mclk;
  end
  // compare and count
  task automatic check(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic final_report;
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // bounded wait for a level, clocks counted, zero if already there
  task automatic wait_lvl(input string what, ref logic sig, input logic lvl, output int n);
    n = 0;
    while (sig !== lvl && n < 400)
    begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    if (sig !== lvl)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen timeout", what, lvl);
      final_report();
    end
  endtask
  // issue one start pulse with its settings
  task automatic start_cycle(input logic wr, input logic [BUS_AW-1:0] a,
      input logic [BUS_DW-1:0] d, input logic multiplex_wait, tw, dly, input logic [WS_W-1:0] ws);
    @(posedge i_mclk);
    i_start    <= 1'h1;
    i_write    <= wr;
    i_addr     <= a;
    i_wdata    <= d;
    i_mux_mode <= multiplex_wait;
    i_tri_ws   <= tw;
    i_rw_delay <= dly;
    i_cycle_ws <= ws;
    @(posedge i_mclk);
    i_start    <= 1'h0;
  endtask
  // whole cycle: latency to done, then trailing gap to idle
  task automatic run_cycle(input logic wr, input logic [BUS_AW-1:0] a,
      input logic [BUS_DW-1:0] d, input logic multiplex_wait, tw, dly, input logic [WS_W-1:0] ws);
    start_cycle(wr, a, d, multiplex_wait, tw, dly, ws);
    wait_lvl("done", o_done, 1'h1, lat);
    wait_lvl("idle", o_busy, 1'h0, gap);
    repeat (8) @(posedge i_mclk);  // ready of this cycle clears, phase kept
  endtask
  ////////////////////////////////////////////////////////////////////////
  // write two words, read one back
  task automatic s_data;
    run_cycle(1'h1, 16'h0003, 16'hA5C3, 1'h0, 1'h0, 1'h0, 4'h1);
    run_cycle(1'h1, 16'h0004, 16'h5A3C, 1'h0, 1'h0, 1'h0, 4'h1);
    run_cycle(1'h0, 16'h0003, 16'h0000, 1'h0, 1'h0, 1'h0, 4'h1);
    check("read data", 16'hA5C3, o_rdata);
    base = lat;
    g0   = gap;
    check("demux gap", 0, g0);
  endtask
  // wait states, delay and trailing waits in mux, tristate and both modes
  task automatic s_timing;
    run_cycle(1'h0, 16'h0003, 16'h0000, 1'h0, 1'h0, 1'h0, 4'h3);
    check("cycle wait latency", 4, lat - base);
    run_cycle(1'h0, 16'h0003, 16'h0000, 1'h0, 1'h0, 1'h1, 4'h1);
    check("delay latency", 2, lat - base);
    for (int m = 1; m < 4; m++)
    begin
      run_cycle(1'h0, 16'h0003, 16'h0000, m[0], m[1], 1'h0, 4'h1);
      check("trailing gap", (m == 3) ? 4 : 2, gap - g0);
      check("mode read data", 16'hA5C3, o_rdata);
    end
  endtask
  // slow ready adds wait states
  task automatic s_ready;
    @(posedge i_mclk);
    i_wait_ws <= 4'h6;
    repeat (7) @(posedge i_mclk);  // with the clock above, eight in all keeps the bus clock phase
    run_cycle(1'h0, 16'h0004, 16'h0000, 1'h0, 1'h0, 1'h0, 4'h1);
    check("ready wait", 1'h1, (lat - base >= 10) && (lat - base <= 12));
    check("slow read data", 16'h5A3C, o_rdata);
  endtask
  // hold during a cycle, request back, regain, then a plain release
  task automatic s_hold;
    start_cycle(1'h0, 16'h0003, 16'h0000, 1'h0, 1'h0, 1'h0, 4'h1);
    i_hold_req <= 1'h1;
    wait_lvl("done", o_done, 1'h1, lat);
    check("held before done", 1'h0, o_held);
    wait_lvl("held", o_held, 1'h1, lat);
    wait_lvl("granted", o_granted, 1'h1, lat);
    check("chip select released", 1'h1, link.chip_select_n);
    check("address released", 16'hFFFF, link.addr_line);
    @(posedge i_mclk);
    i_want_bus <= 1'h1;
    wait_lvl("bus wanted", o_bus_wanted, 1'h1, lat);
    repeat (20)
    begin
      @(posedge i_mclk);
      #1;
      check("held on request", 1'h1, o_held);
    end
    @(posedge i_mclk);
    i_hold_req <= 1'h0;
    i_want_bus <= 1'h0;
    wait_lvl("regain", o_held, 1'h0, lat);
    wait_lvl("request gone", o_bus_wanted, 1'h0, lat);
    @(posedge i_mclk);
    i_hold_req <= 1'h1;
    wait_lvl("held again", o_held, 1'h1, lat);
    @(posedge i_mclk);
    i_hold_req <= 1'h0;
    wait_lvl("plain release", o_held, 1'h0, lat);
    check("no request seen", 1'h0, o_bus_wanted);
    wait_lvl("idle after regain", o_busy, 1'h0, lat);
    run_cycle(1'h0, 16'h0003, 16'h0000, 1'h0, 1'h0, 1'h0, 4'h1);
    check("read after regain", 16'hA5C3, o_rdata);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    n_mismatch   = 0;
    total_checks = 0;
    i_arst_n     = 1'h0;
    i_start      = 1'h0;
    i_write      = 1'h0;
    i_addr       = 16'h0000;
    i_wdata      = 16'h0000;
    i_mux_mode   = 1'h0;
    i_tri_ws     = 1'h0;
    i_rw_delay   = 1'h0;
    i_cycle_ws   = 4'h0;
    i_want_bus   = 1'h0;
    i_hold_req   = 1'h0;
    i_wait_ws    = 4'h0;
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1'h1;
    s_data();
    s_timing();
    s_ready();
    s_hold();
    final_report();
  end
endmodule
`default_nettype wire
